// ===== include/cmctl_pkg.sv
// Package: register map, field positions, reset values and codes of the clock manager control
package cmctl_pkg;
    // ------------------------------------------------------------------
    // Register offsets (register index on the user port)
    // ------------------------------------------------------------------
    localparam logic [2:0] CMCTL_OFS_OUTDIV  = 3'h2;
    localparam logic [2:0] CMCTL_OFS_DUTY1X  = 3'h4;
    localparam logic [2:0] CMCTL_OFS_MODE    = 3'h5;
    localparam logic [2:0] CMCTL_OFS_OUTSRC  = 3'h6;
    localparam logic [2:0] CMCTL_OFS_MGRCTL  = 3'h7;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CMCTL_DUTY_LO_LSB   = 0;
    localparam int CMCTL_DUTY_HI_LSB   = 3;
    localparam int CMCTL_DUTY_RNG_LSB  = 6;
    localparam int CMCTL_MODE_PLL_BIT  = 0;
    localparam int CMCTL_MODE_FB_BIT   = 2;
    localparam int CMCTL_MODE_2X_BIT   = 4;
    localparam int CMCTL_SRC_EDGE_LSB  = 4;
    localparam int CMCTL_SRC_SYS_LSB   = 6;
    localparam int CMCTL_CTL_PWR_BIT   = 0;
    localparam int CMCTL_CTL_RST_BIT   = 1;
    localparam int CMCTL_CTL_DRST_BIT  = 2;
    localparam int CMCTL_CTL_CFGOP_BIT = 6;
    localparam int CMCTL_CTL_GRIMM_BIT = 7;
    localparam int CMCTL_DIV_RST_BIT   = 7;

    // ------------------------------------------------------------------
    // Writable masks (reserved bits drop on write, read zero)
    // ------------------------------------------------------------------
    localparam logic [7:0] CMCTL_MASK_DUTY   = 8'hff;
    localparam logic [7:0] CMCTL_MASK_MODE   = 8'h15;
    localparam logic [7:0] CMCTL_MASK_OUTSRC = 8'hf0;
    localparam logic [7:0] CMCTL_MASK_MGRCTL = 8'hc7;
    localparam logic [7:0] CMCTL_MASK_OUTDIV = 8'h8f;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] CMCTL_RST_DUTY    = 8'h00;
    localparam logic [7:0] CMCTL_RST_MODE    = 8'h00;
    localparam logic [7:0] CMCTL_RST_OUTSRC  = 8'h00;
    localparam logic [7:0] CMCTL_RST_MGRCTL  = 8'h00;
    localparam logic [7:0] CMCTL_RST_OUTDIV  = 8'h00;

    // ------------------------------------------------------------------
    // Duty / delay step: 3.125% = 1/32 period, range = 25% = 8 steps
    // ------------------------------------------------------------------
    localparam logic [4:0] CMCTL_STEPS_PER_RANGE = 5'h08;
    localparam logic [1:0] CMCTL_HALF_RANGE_MAX  = 2'h1;
    localparam logic [3:0] CMCTL_DIV_MODULUS     = 4'h8;

    // ------------------------------------------------------------------
    // Output source codes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CMCTL_SRC_BYPASS = 2'b00,
        CMCTL_SRC_LOOP   = 2'b01,
        CMCTL_SRC_TAPPED = 2'b10,
        CMCTL_SRC_DIVIDE = 2'b11
    } cmctl_src_e;

    // Manager power state
    typedef enum logic [1:0] {
        CMCTL_PS_OFF     = 2'b00,
        CMCTL_PS_CFGHOLD = 2'b01,
        CMCTL_PS_RUN     = 2'b10
    } cmctl_pwr_e;
endpackage

// ===== include/cmctl_div_if.sv
// Interface: settings and resets carried from the control block to the output divider
`timescale 1ns/1ps
interface cmctl_div_if;
    logic       tap_clk_en;  // Tapped delay line clock tick
    logic [3:0] div_value;   // Divide setting, 0 bypass
    logic       div_reset;   // Force divider to start
    logic       div_clk_en;  // Divided clock tick

    modport ctl (output tap_clk_en, output div_value, output div_reset, input div_clk_en);
    modport div (input tap_clk_en, input div_value, input div_reset, output div_clk_en);
endinterface

// ===== hdl/cmctl_out_div.sv
// Output divider: divides the tapped delay line tick by 1 to 8, 0 bypasses
`timescale 1ns/1ps
module cmctl_out_div
    import cmctl_pkg::*;
(
    input  wire logic clk_i,    // System clock
    input  wire logic reset_i,  // Asynchronous reset, high
    cmctl_div_if.div  dv        // Divider settings and output
);
    logic [3:0] count_reg;
    logic [3:0] ratio;
    logic       tick_reg;

    // Values above eight wrap modulo eight; 8 itself divides by eight
    always_comb begin
        ratio = (dv.div_value > CMCTL_DIV_MODULUS) ?
                {1'b0, dv.div_value[2:0]} : dv.div_value;
    end

    // Count input ticks and emit one tick per ratio
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            count_reg <= 4'h0;
            tick_reg  <= 1'b0;
        end else if (dv.div_reset) begin
            count_reg <= 4'h0;
            tick_reg  <= 1'b0;
        end else if (ratio == 4'h0) begin
            count_reg <= 4'h0;
            tick_reg  <= dv.tap_clk_en;
        end else if (dv.tap_clk_en) begin
            if (count_reg + 4'h1 >= ratio) begin
                count_reg <= 4'h0;
                tick_reg  <= 1'b1;
            end else begin
                count_reg <= count_reg + 4'h1;
                tick_reg  <= 1'b0;
            end
        end else begin
            tick_reg <= 1'b0;
        end
    end

    assign dv.div_clk_en = tick_reg;
endmodule

// ===== hdl/cmctl_duty_calc.sv
// Duty / delay calculator: turns the 1x duty register into thirty-seconds of a period
`timescale 1ns/1ps
module cmctl_duty_calc
    import cmctl_pkg::*;
(
    input  wire logic [7:0] duty_reg_i,  // Duty/delay register value
    output logic      [4:0] steps_o,     // Duty in 1/32 period, minus one
    output logic            above_half_o // Selected value above half period
);
    logic [1:0] range;
    logic [2:0] fine;

    // Range picks which fine field is used; the other is ignored
    always_comb begin
        range        = duty_reg_i[CMCTL_DUTY_RNG_LSB +: 2];
        above_half_o = (range > CMCTL_HALF_RANGE_MAX);
        fine         = above_half_o ? duty_reg_i[CMCTL_DUTY_HI_LSB +: 3]
                                    : duty_reg_i[CMCTL_DUTY_LO_LSB +: 3];
        steps_o      = 5'({range, 3'h0}) + 5'(fine);
    end
endmodule

// ===== hdl/cmctl_top.sv
// Clock manager control registers and output steering
`timescale 1ns/1ps
module cmctl_top
    import cmctl_pkg::*;
(
    input  wire logic       clk_i,              // System clock, 40 MHz
    input  wire logic       reset_i,            // Asynchronous reset, high
    input  wire logic       reg_wr_i,           // Register write strobe
    input  wire logic       reg_rd_i,           // Register read strobe
    input  wire logic [2:0] reg_addr_i,         // Register index
    input  wire logic [7:0] reg_wdata_i,        // Register write data
    input  wire logic       global_reset_line_i,// Chip global reset, high, from pin
    input  wire logic       config_done_i,      // Configuration complete, from pin
    input  wire logic       tap_clk_en_i,       // Tapped delay line tick
    input  wire logic       loop_clk_en_i,      // Delay loop output tick
    input  wire logic       in_clk_en_i,        // Input clock tick
    input  wire logic       loop_lock_i,        // Loop lock from analog section
    output logic      [7:0] reg_rdata_o,        // Register read data
    output logic            reg_rvalid_o,       // Read data valid
    output logic            pll_mode_o,         // 1 phase loop, 0 delay loop
    output logic            fb_delay_line_o,    // Phase feedback from delay line
    output logic            out_2x_o,           // 2x output in delay loop mode
    output logic      [4:0] duty_steps_o,       // Duty in 1/32 period, minus one
    output logic            duty_above_half_o,  // Duty above half period
    output logic            analog_pwr_o,       // Analog supply enable
    output logic            mgr_reset_o,        // Whole manager reset
    output logic            loop_reset_o,       // Delay loop generation reset
    output logic            data_bus_oe_o,      // Output data bus enable
    output logic            lock_o,             // Lock indication
    output logic            edge_clk_en_o,      // Edge clock net tick
    output logic            sys_clk_en_o        // System clock net tick
);
    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [7:0] duty_delay_1x_reg;
    logic [7:0] mode_select_reg;
    logic [7:0] output_source_select_reg;
    logic [7:0] manager_control_reg;
    logic [7:0] output_divider_reg;
    logic [1:0] grst_sync_reg;
    logic [1:0] done_sync_reg;
    logic       grst_s;
    logic       done_s;
    logic       grst_hits_mgr;
    logic [4:0] duty_steps;
    logic       duty_above;
    cmctl_pwr_e pwr_state_reg;
    cmctl_pwr_e pwr_state_next;

    cmctl_div_if div_bus ();

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Two flip-flops for the global reset and configuration-complete pins
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            grst_sync_reg <= 2'b00;
            done_sync_reg <= 2'b00;
        end else begin
            grst_sync_reg <= {grst_sync_reg[0], global_reset_line_i};
            done_sync_reg <= {done_sync_reg[0], config_done_i};
        end
    end

    assign grst_s = grst_sync_reg[1];
    assign done_s = done_sync_reg[1];

    // Global reset acts only while the immunity bit is clear
    assign grst_hits_mgr = grst_s && !manager_control_reg[CMCTL_CTL_GRIMM_BIT];

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    // Manager control; the immunity bit itself is never cleared by global reset
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            manager_control_reg <= CMCTL_RST_MGRCTL;
        end else if (reg_wr_i && reg_addr_i == CMCTL_OFS_MGRCTL) begin
            manager_control_reg <= reg_wdata_i & CMCTL_MASK_MGRCTL;
        end
    end

    // Loop setup registers follow global reset unless immune
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            duty_delay_1x_reg        <= CMCTL_RST_DUTY;
            mode_select_reg          <= CMCTL_RST_MODE;
            output_source_select_reg <= CMCTL_RST_OUTSRC;
        end else if (grst_hits_mgr) begin
            duty_delay_1x_reg        <= CMCTL_RST_DUTY;
            mode_select_reg          <= CMCTL_RST_MODE;
            output_source_select_reg <= CMCTL_RST_OUTSRC;
        end else if (reg_wr_i) begin
            if (reg_addr_i == CMCTL_OFS_DUTY1X) begin
                duty_delay_1x_reg <= reg_wdata_i & CMCTL_MASK_DUTY;
            end else if (reg_addr_i == CMCTL_OFS_MODE) begin
                mode_select_reg <= reg_wdata_i & CMCTL_MASK_MODE;
            end else if (reg_addr_i == CMCTL_OFS_OUTSRC) begin
                output_source_select_reg <= reg_wdata_i & CMCTL_MASK_OUTSRC;
            end
        end
    end

    // Output divider register: global reset unless immune, or its own reset bit, restores default; a write wins over both
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            output_divider_reg <= CMCTL_RST_OUTDIV;
        end else if (reg_wr_i && reg_addr_i == CMCTL_OFS_OUTDIV) begin
            output_divider_reg <= reg_wdata_i & CMCTL_MASK_OUTDIV;
        end else if (grst_hits_mgr) begin
            output_divider_reg <= CMCTL_RST_OUTDIV;
        end else if (output_divider_reg[CMCTL_DIV_RST_BIT]) begin
            output_divider_reg <= CMCTL_RST_OUTDIV;
        end
    end

    // ------------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------------
    // Read data registered one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            reg_rdata_o  <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (!reg_rd_i) begin
                reg_rdata_o <= 8'h00;
            end else if (reg_addr_i == CMCTL_OFS_DUTY1X) begin
                reg_rdata_o <= duty_delay_1x_reg;
            end else if (reg_addr_i == CMCTL_OFS_MODE) begin
                reg_rdata_o <= mode_select_reg;
            end else if (reg_addr_i == CMCTL_OFS_OUTSRC) begin
                reg_rdata_o <= output_source_select_reg;
            end else if (reg_addr_i == CMCTL_OFS_MGRCTL) begin
                reg_rdata_o <= manager_control_reg;
            end else if (reg_addr_i == CMCTL_OFS_OUTDIV) begin
                reg_rdata_o <= output_divider_reg;
            end else begin
                reg_rdata_o <= 8'h00;
            end
        end
    end

    // ------------------------------------------------------------------
    // Duty and delay decode
    // ------------------------------------------------------------------
    cmctl_duty_calc u_duty (
        .duty_reg_i   (duty_delay_1x_reg),
        .steps_o      (duty_steps),
        .above_half_o (duty_above)
    );

    // ------------------------------------------------------------------
    // Power and configuration sequencing
    // ------------------------------------------------------------------
    // Off until configuration completes, unless configuration operation enabled
    always_comb begin
        pwr_state_next = CMCTL_PS_OFF;
        case (pwr_state_reg)
            CMCTL_PS_OFF: begin
                if (!done_s && !manager_control_reg[CMCTL_CTL_CFGOP_BIT]) begin
                    pwr_state_next = CMCTL_PS_CFGHOLD;
                end else if (manager_control_reg[CMCTL_CTL_PWR_BIT]) begin
                    pwr_state_next = CMCTL_PS_RUN;
                end else begin
                    pwr_state_next = CMCTL_PS_OFF;
                end
            end
            CMCTL_PS_CFGHOLD: begin
                if (done_s || manager_control_reg[CMCTL_CTL_CFGOP_BIT]) begin
                    pwr_state_next = CMCTL_PS_OFF;
                end else begin
                    pwr_state_next = CMCTL_PS_CFGHOLD;
                end
            end
            CMCTL_PS_RUN: begin
                if (!done_s && !manager_control_reg[CMCTL_CTL_CFGOP_BIT]) begin
                    pwr_state_next = CMCTL_PS_CFGHOLD;
                end else if (!manager_control_reg[CMCTL_CTL_PWR_BIT]) begin
                    pwr_state_next = CMCTL_PS_OFF;
                end else begin
                    pwr_state_next = CMCTL_PS_RUN;
                end
            end
            default: begin
                pwr_state_next = CMCTL_PS_OFF;
            end
        endcase
    end

    // Power state register
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pwr_state_reg <= CMCTL_PS_OFF;
        end else begin
            pwr_state_reg <= pwr_state_next;
        end
    end

    // ------------------------------------------------------------------
    // Loop control outputs
    // ------------------------------------------------------------------
    // Mode, feedback and multiplier; irrelevant bits masked by mode
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pll_mode_o        <= 1'b0;
            fb_delay_line_o   <= 1'b0;
            out_2x_o          <= 1'b0;
            duty_steps_o      <= 5'h00;
            duty_above_half_o <= 1'b0;
        end else begin
            pll_mode_o        <= mode_select_reg[CMCTL_MODE_PLL_BIT];
            fb_delay_line_o   <= mode_select_reg[CMCTL_MODE_PLL_BIT] &&
                                 mode_select_reg[CMCTL_MODE_FB_BIT];
            out_2x_o          <= !mode_select_reg[CMCTL_MODE_PLL_BIT] &&
                                 mode_select_reg[CMCTL_MODE_2X_BIT];
            duty_steps_o      <= duty_steps;
            duty_above_half_o <= duty_above;
        end
    end

    // Supply, resets, data bus and lock
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            analog_pwr_o  <= 1'b0;
            mgr_reset_o   <= 1'b1;
            loop_reset_o  <= 1'b1;
            data_bus_oe_o <= 1'b0;
            lock_o        <= 1'b0;
        end else begin
            analog_pwr_o  <= (pwr_state_reg == CMCTL_PS_RUN);
            mgr_reset_o   <= manager_control_reg[CMCTL_CTL_RST_BIT] || grst_hits_mgr;
            loop_reset_o  <= manager_control_reg[CMCTL_CTL_RST_BIT] ||
                             manager_control_reg[CMCTL_CTL_DRST_BIT] || grst_hits_mgr;
            data_bus_oe_o <= (pwr_state_reg != CMCTL_PS_CFGHOLD);
            lock_o        <= (pwr_state_reg == CMCTL_PS_RUN) && loop_lock_i &&
                             !manager_control_reg[CMCTL_CTL_RST_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Output divider and source steering
    // ------------------------------------------------------------------
    assign div_bus.tap_clk_en = tap_clk_en_i;
    assign div_bus.div_value  = output_divider_reg[3:0];
    assign div_bus.div_reset  = output_divider_reg[CMCTL_DIV_RST_BIT] ||
                                manager_control_reg[CMCTL_CTL_RST_BIT];

    cmctl_out_div u_div (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .dv      (div_bus)
    );

    // Pick the tick driven onto each clock net; loop tick held off while loop reset is set, divided tick while the manager or divider reset bit is set
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            edge_clk_en_o <= 1'b0;
            sys_clk_en_o  <= 1'b0;
        end else begin
            case (output_source_select_reg[CMCTL_SRC_EDGE_LSB +: 2])
                CMCTL_SRC_BYPASS: edge_clk_en_o <= in_clk_en_i;
                CMCTL_SRC_LOOP:   edge_clk_en_o <= loop_clk_en_i && !loop_reset_o;
                CMCTL_SRC_TAPPED: edge_clk_en_o <= tap_clk_en_i;
                default:          edge_clk_en_o <= div_bus.div_clk_en;
            endcase
            case (output_source_select_reg[CMCTL_SRC_SYS_LSB +: 2])
                CMCTL_SRC_BYPASS: sys_clk_en_o <= in_clk_en_i;
                CMCTL_SRC_LOOP:   sys_clk_en_o <= loop_clk_en_i && !loop_reset_o;
                CMCTL_SRC_TAPPED: sys_clk_en_o <= tap_clk_en_i;
                default:          sys_clk_en_o <= 1'b0;
            endcase
        end
    end
endmodule

// ===== verif/cmctl_monitor.sv
// Checker: assertions on the clock manager control ports
`timescale 1ns/1ps
module cmctl_monitor
    import cmctl_pkg::*;
(
    input wire logic       clk_i,               // Clock
    input wire logic       reset_i,             // Reset
    input wire logic       reg_wr_i,            // Write
    input wire logic       reg_rd_i,            // Read
    input wire logic [2:0] reg_addr_i,          // Index
    input wire logic [7:0] reg_wdata_i,         // Data
    input wire logic       global_reset_line_i, // Global reset
    input wire logic [7:0] reg_rdata_o,         // Read data
    input wire logic       pll_mode_o,          // Phase loop
    input wire logic       fb_delay_line_o,     // Feedback pick
    input wire logic       out_2x_o,            // 2x clock
    input wire logic [4:0] duty_steps_o,        // Duty steps
    input wire logic       mgr_reset_o,         // Manager reset
    input wire logic       loop_reset_o,        // Loop reset
    input wire logic       sys_clk_en_o         // System tick
);
    logic [2:0] gq_reg; // Cycles with global reset low
    logic       quiet;  // No global reset in sight
    // ------
    // Quiet counter keeps properties clear of global reset
    // ------
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) gq_reg <= 3'h0;
        else if (global_reset_line_i) gq_reg <= 3'h0;
        else if (gq_reg != 3'h7) gq_reg <= gq_reg + 3'h1;
    end
    assign quiet = (gq_reg == 3'h7) && !global_reset_line_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    property p_duty;
        reg_wr_i && reg_addr_i == CMCTL_OFS_DUTY1X && quiet ##1 quiet |=> duty_steps_o ==
            {$past(reg_wdata_i[7:6], 2), $past(reg_wdata_i[7] ? reg_wdata_i[5:3]
            : reg_wdata_i[2:0], 2)};
    endproperty
    property p_pll;
        reg_wr_i && reg_addr_i == CMCTL_OFS_MODE && quiet ##1 quiet |=>
            pll_mode_o == $past(reg_wdata_i[0], 2);
    endproperty
    property p_fb; fb_delay_line_o |-> pll_mode_o; endproperty
    property p_2x; out_2x_o |-> !pll_mode_o; endproperty
    property p_sys;
        reg_wr_i && reg_addr_i == CMCTL_OFS_OUTSRC && reg_wdata_i[7:6] == 2'h3 && quiet
            ##1 (!reg_wr_i && quiet) [*5] |-> !sys_clk_en_o;
    endproperty
    property p_mrst; reg_wr_i && reg_addr_i == CMCTL_OFS_MGRCTL && reg_wdata_i[1] |=> ##1 mgr_reset_o; endproperty
    property p_lrst; reg_wr_i && reg_addr_i == CMCTL_OFS_MGRCTL && reg_wdata_i[2] |=> ##1 loop_reset_o; endproperty
    property p_rsvd; reg_rd_i && reg_addr_i == CMCTL_OFS_MODE |=> (reg_rdata_o & ~CMCTL_MASK_MODE) == 8'h00; endproperty
    a_duty: assert property (p_duty) else $error("duty steps wrong");
    a_pll: assert property (p_pll) else $error("loop mode wrong");
    a_fb: assert property (p_fb) else $error("feedback pick outside phase loop");
    a_2x: assert property (p_2x) else $error("2x in phase loop");
    a_sys: assert property (p_sys) else $error("tick on reserved source");
    a_mrst: assert property (p_mrst) else $error("manager reset missing");
    a_lrst: assert property (p_lrst) else $error("loop reset missing");
    a_rsvd: assert property (p_rsvd) else $error("reserved mode bits set");
    c_pll: cover property ($rose(pll_mode_o));
    c_fb: cover property (fb_delay_line_o);
    c_mrst: cover property ($rose(mgr_reset_o));
endmodule

// ===== verif/cmctl_user_model.sv
// Partner model: user logic reaching the registers and making clock ticks
`timescale 1ns/1ps
module cmctl_user_model (
    input  wire logic       clk_i,        // Clock
    input  wire logic [7:0] reg_rdata_i,  // Read data
    input  wire logic       reg_rvalid_i, // Read valid
    output logic            reg_wr_o,     // Write
    output logic            reg_rd_o,     // Read
    output logic      [2:0] reg_addr_o,   // Index
    output logic      [7:0] reg_wdata_o,  // Data
    output logic      [2:0] ticks_o       // Tapped, loop, input ticks
);
    initial {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o, ticks_o} = '0;
    // Free running random ticks, changed at the falling edge
    always @(negedge clk_i) ticks_o <= 3'($urandom);
    // One write
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge clk_i);
        {reg_wr_o, reg_addr_o, reg_wdata_o} <= {1'b1, a, d};
        @(negedge clk_i);
        reg_wr_o <= 1'b0;
    endtask
    // One read
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(negedge clk_i);
        {reg_rd_o, reg_addr_o} <= {1'b1, a};
        @(negedge clk_i);
        reg_rd_o <= 1'b0;
        d = (reg_rvalid_i === 1'b1) ? reg_rdata_i : 8'hxx;
    endtask
endmodule

// ===== verif/cmctl_tb_top.sv
// Testbench top: random and corner tests of the clock manager control
`timescale 1ns/1ps
module cmctl_tb_top import cmctl_pkg::*;;
    logic clk = 1'b0, rst = 1'b1, g = 1'b0, cfg = 1'b1, lk = 1'b1;
    logic wr, rd, rv, pll, fb, x2, abv, pwr, mrst, lrst, oe, lock, een, sen;
    logic [2:0] ad, tk;
    logic [7:0] wd, rdat, d, w;
    logic [4:0] stp;
    int err_count = 0, check_count = 0;
    always #12.5 clk = ~clk;
    cmctl_top u_cmctl_top (.clk_i(clk), .reset_i(rst), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_addr_i(ad), .reg_wdata_i(wd), .global_reset_line_i(g), .config_done_i(cfg),
        .tap_clk_en_i(tk[2]), .loop_clk_en_i(tk[1]), .in_clk_en_i(tk[0]), .loop_lock_i(lk),
        .reg_rdata_o(rdat), .reg_rvalid_o(rv), .pll_mode_o(pll), .fb_delay_line_o(fb),
        .out_2x_o(x2), .duty_steps_o(stp), .duty_above_half_o(abv), .analog_pwr_o(pwr),
        .mgr_reset_o(mrst), .loop_reset_o(lrst), .data_bus_oe_o(oe), .lock_o(lock),
        .edge_clk_en_o(een), .sys_clk_en_o(sen));
    cmctl_user_model u_cmctl_user_model (.clk_i(clk), .reg_rdata_i(rdat), .reg_rvalid_i(rv),
        .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(ad), .reg_wdata_o(wd), .ticks_o(tk));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        check_count++;
        if (e !== s) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Writable bits per index; divider reset bit clears itself
    function automatic logic [7:0] msk(input logic [2:0] a);
        return a == 3'h2 ? 8'h0f : a == 3'h4 ? 8'hff : a == 3'h5 ? 8'h15 :
            a == 3'h6 ? 8'hf0 : a == 3'h7 ? 8'hc7 : 8'h00;
    endfunction
    // Wait a bounded time for power state bits, then compare
    task automatic pwait(input string n, input logic [2:0] e);
        repeat (12) if ({pwr, oe, lock} !== e) @(negedge clk);
        chk(n, {5'h0, e}, {5'h0, pwr, oe, lock});
    endtask
    initial begin
        void'($urandom(49));
        repeat (3) @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 24; i++) begin
            w = $urandom;
            u_cmctl_user_model.rd(i[2:0], d);
            if (i < 8) chk("reset value", 8'h00, d);
            u_cmctl_user_model.wr(i[2:0], w);
            u_cmctl_user_model.rd(i[2:0], d);
            chk("readback", (i % 8 == 2 && w[7]) ? 8'h00 : w & msk(i[2:0]), d);
        end
        $display("test registers done");
        u_cmctl_user_model.wr(CMCTL_OFS_MGRCTL, 8'h01);
        for (int i = 0; i < 12; i++) begin
            w = i == 0 ? 8'h00 : i == 1 ? 8'h7c : i == 2 ? 8'hf0 : i == 3 ? 8'hff : $urandom;
            u_cmctl_user_model.wr(CMCTL_OFS_DUTY1X, w);
            @(negedge clk);
            chk("duty", {w[7:6], w[7] ? w[5:3] : w[2:0], w[7]}, {stp, abv});
        end
        for (int i = 7; i >= 0; i--) begin
            w = (8'($urandom) & 8'hea) | {3'h0, i[2], 1'b0, i[1], 1'b0, i[0]};
            u_cmctl_user_model.wr(CMCTL_OFS_MODE, w);
            @(negedge clk);
            chk("mode", {5'h0, w[0], w[2] & w[0], w[4] & ~w[0]}, {5'h0, pll, fb, x2});
        end
        for (int c = 0; c < 4; c++) begin
            u_cmctl_user_model.wr(CMCTL_OFS_OUTSRC, {c[1:0], c[1:0], 4'hf});
            repeat (12) begin
                @(negedge clk);
                if (c < 3) chk("edge tick", {7'h0, tk[c]}, {7'h0, een});
                chk("sys tick", {7'h0, c < 3 ? tk[c] : 1'b0}, {7'h0, sen});
            end
        end
        $display("test fields done");
        u_cmctl_user_model.wr(CMCTL_OFS_MGRCTL, 8'h06);
        @(negedge clk);
        chk("resets", 8'h03, {6'h0, mrst, lrst});
        u_cmctl_user_model.wr(CMCTL_OFS_MGRCTL, 8'h04);
        @(negedge clk);
        chk("loop reset", 8'h01, {6'h0, mrst, lrst});
        cfg = 1'b0;
        u_cmctl_user_model.wr(CMCTL_OFS_MGRCTL, 8'h01);
        repeat (6) @(negedge clk);
        pwait("config hold", 3'h0);
        u_cmctl_user_model.wr(CMCTL_OFS_MGRCTL, 8'h41);
        pwait("run in config", 3'h7);
        cfg = 1'b1;
        u_cmctl_user_model.wr(CMCTL_OFS_MGRCTL, 8'h00);
        pwait("supply off", 3'h2);
        $display("test control done");
        for (int k = 0; k < 2; k++) begin
            u_cmctl_user_model.wr(CMCTL_OFS_MGRCTL, {k[0], 7'h01});
            u_cmctl_user_model.wr(CMCTL_OFS_DUTY1X, 8'h55);
            u_cmctl_user_model.wr(CMCTL_OFS_OUTDIV, 8'h05);
            g = 1'b1;
            repeat (4) @(negedge clk);
            chk("global reset", {7'h0, ~k[0]}, {7'h0, mrst});
            g = 1'b0;
            repeat (4) @(negedge clk);
            u_cmctl_user_model.rd(CMCTL_OFS_DUTY1X, d);
            chk("duty kept", k[0] ? 8'h55 : 8'h00, d);
            u_cmctl_user_model.rd(CMCTL_OFS_OUTDIV, d);
            chk("divider kept", k[0] ? 8'h05 : 8'h00, d);
        end
        $display("test global reset done");
        test_done();
    end
endmodule
bind cmctl_top cmctl_monitor u_cmctl_monitor (.*);
